/* dbt_defines.svh */
`ifndef DBT_DEFINES_SVH
`define DBT_DEFINES_SVH
// register indexes; byte address is four times the index
`define DBT_IDX_CONTROL 16'hfe18
`define DBT_IDX_PRESCALE 16'hfe19
`define DBT_IDX_LOW_COUNT 16'hfe1a
`define DBT_IDX_HIGH_COUNT 16'hfe1b
`define DBT_IDX_LOW_MATCH 16'hfe1c
`define DBT_IDX_HIGH_MATCH 16'hfe1d
`define DBT_IDX_EVENT_SEL 16'hfe1e
`define DBT_RESET_BYTE 8'h00
`define DBT_FULL_MATCH 8'hff
`define DBT_BIT_HIGH_FLAG 3
`define DBT_BIT_LOW_FLAG 1
`define DBT_BIT_EVENT_SEL 0
`define DBT_CLK_PERIOD_NS 5
`define DBT_AXI_OKAY 2'h0
`define DBT_AXI_SLVERR 2'h2
`endif

/* dbt_pkg.sv */
package dbt_pkg;
  typedef struct packed {
    logic high_half_run;
    logic low_half_run;
    logic cascade_select;
    logic output_mode_select;
    logic high_match_flag;
    logic high_irq_enable;
    logic low_match_flag;
    logic low_irq_enable;
  } dbt_control_type;

  typedef struct packed {
    logic high_prescale_enable;
    logic [2:0] high_prescale_code;
    logic low_prescale_enable;
    logic [2:0] low_prescale_code;
  } dbt_prescale_type;

  typedef enum logic [1:0] {
    DBT_MODE_SPLIT_TOGGLE,
    DBT_MODE_SPLIT_PWM,
    DBT_MODE_LONG_TOGGLE,
    DBT_MODE_LONG_PWM
  } dbt_mode_type;
endpackage

/* dbt_timer.sv */
`timescale 1ns/1ps
`include "dbt_defines.svh"
module dbt_timer #(
  parameter int ADDR_W = 18
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // external event and waveforms
  input wire logic EVENT_IN,
  output logic LOW_WAVE_OUTPUT,
  output logic HIGH_WAVE_OUTPUT,
  output logic IRQ_REQUEST
);
  dbt_pkg::dbt_control_type ctrl_reg;
  dbt_pkg::dbt_prescale_type presc_reg;
  dbt_pkg::dbt_mode_type mode;
  logic [7:0] match_reg [2];
  logic [7:0] buf_reg [2];
  logic [7:0] cnt_reg [2];
  logic [7:0] cnt_next [2];
  logic [7:0] pcnt_reg [2];
  logic [7:0] pdiv_reg [2];
  logic [7:0] pdiv_next [2];
  logic wave_reg [2];
  logic run [2];
  logic src [2];
  logic ptick [2];
  logic match_ev [2];
  logic ovf_ev [2];
  logic zero_ev [2];
  logic clr_on_match [2];
  logic pwm_out [2];
  logic event_sel_reg;
  logic div2_reg;
  logic ev_meta_reg, ev_sync_reg, ev_last_reg;
  logic ev_edge;
  logic aw_full_reg, w_full_reg;
  logic [15:0] aw_idx_reg;
  logic [7:0] w_data_reg;
  logic w_strb_reg;
  logic do_write;
  logic aw_hit;

  // terminal prescaler count: code n divides by 2^(n+1)
  function automatic logic [7:0] div_term(input logic en,
                                          input logic [2:0] code);
    logic [8:0] d;
    d = 9'h002 << code;
    div_term = en ? 8'(d - 9'h001) : 8'h00;
  endfunction

  function automatic logic idx_ok(input logic [15:0] idx);
    idx_ok = (idx >= `DBT_IDX_CONTROL) && (idx <= `DBT_IDX_EVENT_SEL);
  endfunction

  assign mode = dbt_pkg::dbt_mode_type'({ctrl_reg.cascade_select,
                                         ctrl_reg.output_mode_select});
  assign run[0] = ctrl_reg.low_half_run;
  assign run[1] = ctrl_reg.high_half_run;
  assign pdiv_next[0] = div_term(presc_reg.low_prescale_enable,
                                 presc_reg.low_prescale_code);
  assign pdiv_next[1] = div_term(presc_reg.high_prescale_enable,
                                 presc_reg.high_prescale_code);
  // low counter clears on match in modes 0 and 2, high in all but mode 1
  assign clr_on_match[0] = !ctrl_reg.output_mode_select;
  assign clr_on_match[1] = (mode != dbt_pkg::DBT_MODE_SPLIT_PWM);
  assign pwm_out[0] = ctrl_reg.output_mode_select;
  assign pwm_out[1] = (mode == dbt_pkg::DBT_MODE_SPLIT_PWM);

  // event pin: two flops, then edge detect on the synchronised copy
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ev_meta_reg <= 1'b0;
      ev_sync_reg <= 1'b0;
      ev_last_reg <= 1'b0;
    end else begin
      ev_meta_reg <= EVENT_IN;
      ev_sync_reg <= ev_meta_reg;
      ev_last_reg <= ev_sync_reg;
    end
  end
  assign ev_edge = ev_sync_reg && !ev_last_reg;

  // half-rate enable for the 2-cycle count sources
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div2_reg <= 1'b0;
    end else begin
      div2_reg <= !div2_reg;
    end
  end

  // source selection and tick chain; the high half in mode 2 and 3
  // sees the low events in the same cycle, so no extra latency
  always_comb begin
    if (ctrl_reg.output_mode_select) begin
      src[0] = 1'b1;
    end else begin
      src[0] = event_sel_reg ? ev_edge : div2_reg;
    end
    ptick[0] = run[0] && src[0] && (pcnt_reg[0] == pdiv_reg[0]);
    match_ev[0] = ptick[0] && (cnt_reg[0] == buf_reg[0]);
    cnt_next[0] = (match_ev[0] && clr_on_match[0]) ? 8'h00
                  : 8'(cnt_reg[0] + 8'h01);
    ovf_ev[0] = ptick[0] && !(match_ev[0] && clr_on_match[0])
                && (cnt_reg[0] == 8'hff);
    zero_ev[0] = ptick[0] && (cnt_next[0] == 8'h00);
    case (mode)
      dbt_pkg::DBT_MODE_SPLIT_TOGGLE: src[1] = div2_reg;
      dbt_pkg::DBT_MODE_SPLIT_PWM: src[1] = 1'b1;
      dbt_pkg::DBT_MODE_LONG_TOGGLE: src[1] = match_ev[0];
      dbt_pkg::DBT_MODE_LONG_PWM: src[1] = ovf_ev[0];
      default: src[1] = 1'b0;
    endcase
    ptick[1] = run[1] && src[1] && (pcnt_reg[1] == pdiv_reg[1]);
    match_ev[1] = ptick[1] && (cnt_reg[1] == buf_reg[1]);
    cnt_next[1] = (match_ev[1] && clr_on_match[1]) ? 8'h00
                  : 8'(cnt_reg[1] + 8'h01);
    ovf_ev[1] = ptick[1] && !(match_ev[1] && clr_on_match[1])
                && (cnt_reg[1] == 8'hff);
    zero_ev[1] = ptick[1] && (cnt_next[1] == 8'h00);
  end

  // counters, prescalers and match buffers for both halves
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int h = 0; h < 2; h++) begin
        cnt_reg[h] <= `DBT_RESET_BYTE;
        pcnt_reg[h] <= `DBT_RESET_BYTE;
        pdiv_reg[h] <= `DBT_RESET_BYTE;
        buf_reg[h] <= `DBT_RESET_BYTE;
      end
    end else begin
      for (int h = 0; h < 2; h++) begin
        if (!run[h]) begin
          cnt_reg[h] <= 8'h00;
          pcnt_reg[h] <= 8'h00;
          buf_reg[h] <= match_reg[h];
          pdiv_reg[h] <= pdiv_next[h];
        end else begin
          if (src[h]) begin
            pcnt_reg[h] <= ptick[h] ? 8'h00 : 8'(pcnt_reg[h] + 8'h01);
          end
          if (ptick[h]) begin
            cnt_reg[h] <= cnt_next[h];
          end
          // new match value and divider take hold together at zero
          if (zero_ev[h]) begin
            buf_reg[h] <= match_reg[h];
            pdiv_reg[h] <= pdiv_next[h];
          end
        end
      end
    end
  end

  // waveform outputs
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wave_reg[0] <= 1'b1;
      wave_reg[1] <= 1'b1;
    end else begin
      for (int h = 0; h < 2; h++) begin
        if (!run[h]) begin
          wave_reg[h] <= 1'b1;
        end else if (match_reg[h] == `DBT_FULL_MATCH) begin
          wave_reg[h] <= 1'b0;
        end else if (pwm_out[h]) begin
          if (match_ev[h]) begin
            wave_reg[h] <= 1'b1;
          end else if (ovf_ev[h]) begin
            wave_reg[h] <= 1'b0;
          end
        end else if (match_ev[h]) begin
          wave_reg[h] <= !wave_reg[h];
        end
      end
    end
  end
  assign LOW_WAVE_OUTPUT = wave_reg[0];
  assign HIGH_WAVE_OUTPUT = wave_reg[1];

  // a flag event in the cycle of a clearing write still sets the flag
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg <= dbt_pkg::dbt_control_type'(`DBT_RESET_BYTE);
      presc_reg <= dbt_pkg::dbt_prescale_type'(`DBT_RESET_BYTE);
      match_reg[0] <= `DBT_RESET_BYTE;
      match_reg[1] <= `DBT_RESET_BYTE;
      event_sel_reg <= 1'b0;
    end else begin
      if (do_write && aw_idx_reg == `DBT_IDX_CONTROL) begin
        ctrl_reg <= dbt_pkg::dbt_control_type'(w_data_reg);
        ctrl_reg.high_match_flag <= zero_ev[1] || (ctrl_reg.high_match_flag
          && w_data_reg[`DBT_BIT_HIGH_FLAG]);
        ctrl_reg.low_match_flag <= zero_ev[0] || (ctrl_reg.low_match_flag
          && w_data_reg[`DBT_BIT_LOW_FLAG]);
      end else begin
        if (zero_ev[1]) begin
          ctrl_reg.high_match_flag <= 1'b1;
        end
        if (zero_ev[0]) begin
          ctrl_reg.low_match_flag <= 1'b1;
        end
      end
      if (do_write && aw_idx_reg == `DBT_IDX_PRESCALE) begin
        presc_reg <= dbt_pkg::dbt_prescale_type'(w_data_reg);
      end
      if (do_write && aw_idx_reg == `DBT_IDX_LOW_MATCH) begin
        match_reg[0] <= w_data_reg;
      end
      if (do_write && aw_idx_reg == `DBT_IDX_HIGH_MATCH) begin
        match_reg[1] <= w_data_reg;
      end
      if (do_write && aw_idx_reg == `DBT_IDX_EVENT_SEL) begin
        event_sel_reg <= w_data_reg[`DBT_BIT_EVENT_SEL];
      end
    end
  end

  assign IRQ_REQUEST = (ctrl_reg.high_match_flag
                        && ctrl_reg.high_irq_enable)
                       || (ctrl_reg.low_match_flag
                           && ctrl_reg.low_irq_enable);

  // axi write path: address and data are held until both are present
  assign S_AXI_AWREADY = !aw_full_reg && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_full_reg && !S_AXI_BVALID;
  assign do_write = aw_full_reg && w_full_reg && !S_AXI_BVALID
                    && w_strb_reg;
  assign aw_hit = idx_ok(aw_idx_reg);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_idx_reg <= 16'h0000;
      w_data_reg <= 8'h00;
      w_strb_reg <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `DBT_AXI_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full_reg <= 1'b1;
        aw_idx_reg <= S_AXI_AWADDR[17:2];
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA[7:0];
        w_strb_reg <= S_AXI_WSTRB[0];
      end
      if (aw_full_reg && w_full_reg && !S_AXI_BVALID) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= aw_hit ? `DBT_AXI_OKAY : `DBT_AXI_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // axi read path: one read in flight, data registered
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `DBT_AXI_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= `DBT_AXI_OKAY;
      case (S_AXI_ARADDR[17:2])
        `DBT_IDX_CONTROL: S_AXI_RDATA <= {24'h000000, ctrl_reg};
        `DBT_IDX_PRESCALE: S_AXI_RDATA <= {24'h000000, presc_reg};
        `DBT_IDX_LOW_COUNT: S_AXI_RDATA <= {24'h000000, cnt_reg[0]};
        `DBT_IDX_HIGH_COUNT: S_AXI_RDATA <= {24'h000000, cnt_reg[1]};
        `DBT_IDX_LOW_MATCH: S_AXI_RDATA <= {24'h000000, match_reg[0]};
        `DBT_IDX_HIGH_MATCH: S_AXI_RDATA <= {24'h000000, match_reg[1]};
        `DBT_IDX_EVENT_SEL: S_AXI_RDATA <= {31'h00000000, event_sel_reg};
        default: begin
          S_AXI_RDATA <= 32'h0000_0000;
          S_AXI_RRESP <= `DBT_AXI_SLVERR;
        end
      endcase
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  a_stop_holds_low: assert property (
    @(posedge CLK) disable iff (!RST_N)
    !run[0] |=> cnt_reg[0] == 8'h00 && buf_reg[0] == $past(match_reg[0])
  ) else $error("stopped low half not held");
  a_stop_holds_high: assert property (
    @(posedge CLK) disable iff (!RST_N)
    !run[1] |=> cnt_reg[1] == 8'h00 && buf_reg[1] == $past(match_reg[1])
  ) else $error("stopped high half not held");
  a_high_flag_set: assert property (
    @(posedge CLK) disable iff (!RST_N)
    zero_ev[1] |=> ctrl_reg.high_match_flag
      && (IRQ_REQUEST || !ctrl_reg.high_irq_enable)
  ) else $error("high flag or request missing");
  a_low_flag_set: assert property (
    @(posedge CLK) disable iff (!RST_N)
    zero_ev[0] |=> ctrl_reg.low_match_flag
      && (IRQ_REQUEST || !ctrl_reg.low_irq_enable)
  ) else $error("low flag or request missing");
  a_low_irq_level: assert property (
    @(posedge CLK) disable iff (!RST_N)
    ctrl_reg.low_match_flag && ctrl_reg.low_irq_enable |-> IRQ_REQUEST
  ) else $error("low interrupt request missing");
  a_toggle_on_match: assert property (
    @(posedge CLK) disable iff (!RST_N)
    match_ev[0] && !pwm_out[0] && match_reg[0] != 8'hff
      |=> wave_reg[0] != $past(wave_reg[0]) || !run[0]
      || match_reg[0] == 8'hff
  ) else $error("low toggle missed a match");
  a_pwm_overflow_clear: assert property (
    @(posedge CLK) disable iff (!RST_N)
    ovf_ev[0] && pwm_out[0] && !match_ev[0] && match_reg[0] != 8'hff
      |=> !wave_reg[0] || !run[0]
  ) else $error("pwm not cleared on overflow");
  a_pwm_match_set: assert property (
    @(posedge CLK) disable iff (!RST_N)
    match_ev[0] && pwm_out[0] && match_reg[0] != 8'hff |=> wave_reg[0]
  ) else $error("pwm not set on match");
  a_full_match_low: assert property (
    @(posedge CLK) disable iff (!RST_N)
    run[0] && match_reg[0] == 8'hff |=> !LOW_WAVE_OUTPUT
  ) else $error("low output not forced low");
  a_match_clears_count: assert property (
    @(posedge CLK) disable iff (!RST_N)
    match_ev[1] && clr_on_match[1] |=> cnt_reg[1] == 8'h00
  ) else $error("high counter not cleared on match");
  a_low_counts_tick: assert property (
    @(posedge CLK) disable iff (!RST_N)
    ptick[0] && !match_ev[0] |=> cnt_reg[0] == 8'($past(cnt_reg[0]) + 8'h01)
  ) else $error("low counter missed a tick");
  a_divider_hold: assert property (
    @(posedge CLK) disable iff (!RST_N)
    run[0] && !zero_ev[0] ##1 run[0] |-> $stable(pdiv_reg[0])
  ) else $error("prescaler changed outside reload");
  a_low_reload_hold: assert property (
    @(posedge CLK) disable iff (!RST_N)
    run[0] && !zero_ev[0] ##1 run[0] |-> $stable(buf_reg[0])
  ) else $error("low buffer changed outside reload");
  a_high_reload: assert property (
    @(posedge CLK) disable iff (!RST_N)
    zero_ev[1] |=> buf_reg[1] == $past(match_reg[1])
  ) else $error("high buffer not reloaded at zero");
  a_stop_wave_high: assert property (
    @(posedge CLK) disable iff (!RST_N)
    !run[1] ##1 !run[1] |-> HIGH_WAVE_OUTPUT
  ) else $error("stopped high output not high");
  a_event_edge_tick: assert property (
    @(posedge CLK) disable iff (!RST_N)
    $rose(EVENT_IN) ##1 EVENT_IN |=> ev_edge
  ) else $error("event edge not seen after sync");
  a_write_answer: assert property (
    @(posedge CLK) disable iff (!RST_N)
    aw_full_reg && w_full_reg && !S_AXI_BVALID |=> S_AXI_BVALID
  ) else $error("write response late");
  a_read_answer: assert property (
    @(posedge CLK) disable iff (!RST_N)
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID
  ) else $error("read response late");
endmodule

/* dual_byte_timer_pwm_toggle_bench.sv */
`timescale 1ns/1ps
`include "dbt_defines.svh"
module dual_byte_timer_pwm_toggle_bench;
  logic CLK, RST_N, EVENT_IN;
  logic [17:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, S_AXI_RREADY;
  logic LOW_WAVE_OUTPUT, HIGH_WAVE_OUTPUT, IRQ_REQUEST;
  logic ev_run;
  logic [1:0] ev_phase;
  int err_total;
  int comparisons;

  dbt_timer #(.ADDR_W(18)) dut (
    .CLK(CLK), .RST_N(RST_N), .EVENT_IN(EVENT_IN),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWPROT(3'h0),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .LOW_WAVE_OUTPUT(LOW_WAVE_OUTPUT),
    .HIGH_WAVE_OUTPUT(HIGH_WAVE_OUTPUT), .IRQ_REQUEST(IRQ_REQUEST));

  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  // events two cycles high every four, so a gap in cycles is four per event
  always @(posedge CLK) begin
    if (!RST_N) begin
      ev_phase <= 2'h0;
      EVENT_IN <= 1'b0;
    end else begin
      ev_phase <= ev_phase + 2'h1;
      EVENT_IN <= ev_run & ev_phase[1];
    end
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic give_up;
    err_total++;
    $display("[ERR] %0t wait ran out", $time);
    final_report();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // readiness is sampled at the falling edge: it is what the next
  // rising edge takes, since inputs only move just after rising edges
  task automatic reg_write(input logic [15:0] idx, input logic [7:0] v,
      input logic [1:0] resp);
    logic aw_done, w_done;
    int n;
    aw_done = 1'b0;
    w_done = 1'b0;
    n = 0;
    @(posedge CLK);
    S_AXI_AWADDR <= {idx, 2'h0};
    S_AXI_WDATA <= {24'h0, v};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge CLK);
      if (S_AXI_AWVALID && S_AXI_AWREADY) aw_done = 1'b1;
      if (S_AXI_WVALID && S_AXI_WREADY) w_done = 1'b1;
      if (++n > 1000) give_up();
      @(posedge CLK);
      if (aw_done) S_AXI_AWVALID <= 1'b0;
      if (w_done) S_AXI_WVALID <= 1'b0;
    end
    n = 0;
    do begin
      @(negedge CLK);
      if (++n > 1000) give_up();
    end while (S_AXI_BVALID !== 1'b1);
    check(S_AXI_BRESP, resp);
    @(posedge CLK);
    S_AXI_BREADY <= 1'b0;
    // return at a falling edge so callers look at settled outputs
    @(negedge CLK);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] v);
    reg_write(idx, v, `DBT_AXI_OKAY);
  endtask

  task automatic reg_read(input logic [15:0] idx, output logic [31:0] d,
      input logic [1:0] resp);
    int n;
    n = 0;
    @(posedge CLK);
    S_AXI_ARADDR <= {idx, 2'h0};
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(negedge CLK);
      if (++n > 1000) give_up();
    end while (S_AXI_ARREADY !== 1'b1);
    @(posedge CLK);
    S_AXI_ARVALID <= 1'b0;
    do begin
      @(negedge CLK);
      if (++n > 2000) give_up();
    end while (S_AXI_RVALID !== 1'b1);
    d = S_AXI_RDATA;
    check(S_AXI_RRESP, resp);
    @(posedge CLK);
    S_AXI_RREADY <= 1'b0;
    @(negedge CLK);
  endtask

  task automatic expect_reg(input logic [15:0] idx, input logic [31:0] exp,
      input logic [1:0] resp);
    logic [31:0] d;
    reg_read(idx, d, resp);
    check(d, exp);
  endtask

  task automatic setup(input logic [7:0] ctl, pre, lm, hm);
    wr(`DBT_IDX_CONTROL, 8'h00);
    wr(`DBT_IDX_PRESCALE, pre);
    wr(`DBT_IDX_LOW_MATCH, lm);
    wr(`DBT_IDX_HIGH_MATCH, hm);
    wr(`DBT_IDX_CONTROL, ctl);
  endtask

  // cycles between two wave changes, rising ones only when rise is set
  task automatic edge_gap(input bit high, input bit rise, output int gap);
    logic prev, cur;
    int seen, n;
    seen = 0;
    n = 0;
    gap = 0;
    prev = high ? HIGH_WAVE_OUTPUT : LOW_WAVE_OUTPUT;
    while (seen < 2) begin
      @(negedge CLK);
      cur = high ? HIGH_WAVE_OUTPUT : LOW_WAVE_OUTPUT;
      if (seen == 1) gap++;
      if (cur !== prev && (!rise || cur)) seen++;
      prev = cur;
      if (++n > 20000) give_up();
    end
  endtask

  // the first gap after a start may be short, so only the second counts
  task automatic gap_check(input bit high, input bit rise, input int exp);
    int g;
    edge_gap(high, rise, g);
    edge_gap(high, rise, g);
    check(g, exp);
  endtask

  task automatic s_reset_regs;
    check(LOW_WAVE_OUTPUT, 1'b1);
    check(HIGH_WAVE_OUTPUT, 1'b1);
    check(IRQ_REQUEST, 1'b0);
    for (int i = 0; i < 6; i++) begin
      expect_reg(`DBT_IDX_CONTROL + 16'(i), 0, `DBT_AXI_OKAY);
    end
    expect_reg(16'h0010, 0, `DBT_AXI_SLVERR);
    reg_write(16'h0010, 8'h5a, `DBT_AXI_SLVERR);
    wr(`DBT_IDX_LOW_COUNT, 8'h5a);
    wr(`DBT_IDX_HIGH_COUNT, 8'ha5);
    expect_reg(`DBT_IDX_LOW_COUNT, 0, `DBT_AXI_OKAY);
    expect_reg(`DBT_IDX_HIGH_COUNT, 0, `DBT_AXI_OKAY);
    wr(`DBT_IDX_LOW_MATCH, 8'h96);
    wr(`DBT_IDX_HIGH_MATCH, 8'h69);
    wr(`DBT_IDX_PRESCALE, 8'h3c);
    expect_reg(`DBT_IDX_LOW_MATCH, 8'h96, `DBT_AXI_OKAY);
    expect_reg(`DBT_IDX_HIGH_MATCH, 8'h69, `DBT_AXI_OKAY);
    expect_reg(`DBT_IDX_PRESCALE, 8'h3c, `DBT_AXI_OKAY);
  endtask

  task automatic s_toggle_irq;
    logic [31:0] d;
    for (int c = 0; c < 3; c++) begin
      setup(8'hc0, {5'h01, 3'(c)}, 8'h03, 8'h02);
      gap_check(0, 0, 16 << c);
      gap_check(1, 0, 6);
    end
    reg_read(`DBT_IDX_CONTROL, d, `DBT_AXI_OKAY);
    check(d[3:1], 3'h5);
    wr(`DBT_IDX_CONTROL, 8'hce);
    check(IRQ_REQUEST, 1'b1);
    // stop before clearing so a fresh flag event cannot win the write
    wr(`DBT_IDX_CONTROL, 8'h0e);
    check(LOW_WAVE_OUTPUT, 1'b1);
    expect_reg(`DBT_IDX_LOW_COUNT, 0, `DBT_AXI_OKAY);
    wr(`DBT_IDX_CONTROL, 8'h06);
    check(IRQ_REQUEST, 1'b0);
    wr(`DBT_IDX_CONTROL, 8'h03);
    check(IRQ_REQUEST, 1'b1);
    wr(`DBT_IDX_CONTROL, 8'h01);
    check(IRQ_REQUEST, 1'b0);
    expect_reg(`DBT_IDX_CONTROL, 8'h01, `DBT_AXI_OKAY);
  endtask

  task automatic s_modes;
    setup(8'hd0, 8'h98, 8'h3f, 8'h10);
    gap_check(0, 1, 512);
    gap_check(1, 1, 1024);
    setup(8'he0, 8'h00, 8'h01, 8'h01);
    gap_check(0, 0, 4);
    gap_check(1, 0, 8);
    setup(8'hf0, 8'h00, 8'h20, 8'h00);
    gap_check(0, 1, 256);
    gap_check(1, 0, 256);
  endtask

  task automatic s_full_match;
    logic seen_high;
    setup(8'h40, 8'h00, 8'hff, 8'h00);
    repeat (8) @(negedge CLK);
    seen_high = 1'b0;
    repeat (600) begin
      @(negedge CLK);
      seen_high = seen_high | LOW_WAVE_OUTPUT;
    end
    check(seen_high, 1'b0);
    check(HIGH_WAVE_OUTPUT, 1'b1);
  endtask

  task automatic s_events_reload;
    wr(`DBT_IDX_EVENT_SEL, 8'h01);
    ev_run <= 1'b1;
    setup(8'h40, 8'h08, 8'h02, 8'h00);
    gap_check(0, 0, 24);
    ev_run <= 1'b0;
    wr(`DBT_IDX_EVENT_SEL, 8'h00);
    setup(8'h40, 8'h00, 8'h07, 8'h00);
    gap_check(0, 0, 16);
    wr(`DBT_IDX_PRESCALE, 8'h09);
    wr(`DBT_IDX_LOW_MATCH, 8'h03);
    gap_check(0, 0, 32);
  endtask

  initial begin
    err_total = 0;
    comparisons = 0;
    RST_N = 1'b0;
    ev_run = 1'b0;
    S_AXI_AWADDR = 18'h0;
    S_AXI_ARADDR = 18'h0;
    S_AXI_WDATA = 32'h0;
    S_AXI_AWVALID = 1'b0;
    S_AXI_WVALID = 1'b0;
    S_AXI_BREADY = 1'b0;
    S_AXI_ARVALID = 1'b0;
    S_AXI_RREADY = 1'b0;
    repeat (4) @(posedge CLK);
    RST_N <= 1'b1;
    s_reset_regs();
    s_toggle_irq();
    s_modes();
    s_full_match();
    s_events_reload();
    final_report();
  end
endmodule
